/* File: design/scp_consts.svh */
/*
  Constants of the phase-one serial controller: field positions inside
  the control words, timing extras and limits.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SCP_CONSTS_SVH
`define SCP_CONSTS_SVH

// ==========================================================
// global control word
`define SCP_GCR_CTRL_BIT 0

// ==========================================================
// format configuration word
`define SCP_FMT_LEN_MSB 4
`define SCP_FMT_LEN_LSB 0
`define SCP_FMT_DIV_MSB 15
`define SCP_FMT_DIV_LSB 8
`define SCP_FMT_PHASE_BIT 16
`define SCP_FMT_POL_BIT 17
`define SCP_FMT_HOLD_BIT 28

// ==========================================================
// delay configuration word
`define SCP_DLY_C2T_MSB 31
`define SCP_DLY_C2T_LSB 24
`define SCP_DLY_T2C_MSB 23
`define SCP_DLY_T2C_LSB 16

// ==========================================================
// timing, in bus clock cycles unless named in ns
`define SCP_SETUP_EXTRA 10'h002
`define SCP_SETUP_EXTRA_HOLD 10'h003
`define SCP_HOLD_EXTRA 1
`define SCP_DIV_ZERO_PERIOD 9'h002
`define SCP_MAX_PERIOD_CYC 9'h100
`define SCP_MIN_PERIOD_NS 25

`endif

/* File: design/scp_pkg.sv */
/*
  Types of the phase-one serial controller.
  Assumes nothing of its surroundings.
*/
package scp_pkg;
  // transfer sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_ACTIVE,
    ST_INACTIVE,
    ST_HOLD
  } scp_state_t;
endpackage

/* File: design/scp_half_timer.sv */
/*
  Half-period timer of the serial clock prescaler.
  Assumes run is held for whole halves and div is stable while it runs.
*/
`timescale 1ns/1ns
`default_nettype none
`include "scp_consts.svh"

module scp_half_timer (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // control
  input wire logic run,
  input wire logic second_half,
  input wire logic [7:0] div,
  // results
  output logic tick,
  output logic [8:0] period,
  output logic [7:0] first_len
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] second_len;
  logic [7:0] len;

  // divider 0 behaves as 1; odd periods give the extra cycle to the 2nd half
  assign period = (div == 8'h00) ? `SCP_DIV_ZERO_PERIOD : {1'b0, div} + 9'h001;
  assign first_len = period[8:1];
  assign second_len = 8'(period - {1'b0, first_len});
  assign len = second_half ? second_len : first_len;
  assign tick = run && (cnt_q == len - 8'h01);
  assign cnt_d = (!run || tick) ? 8'h00 : cnt_q + 8'h01;

  // half counter, restarts at every tick
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt_q <= 8'h00;
    end else if (ce) begin
      cnt_q <= cnt_d;
    end
  end
endmodule // scp_half_timer
`default_nettype wire

/* File: design/scp_ctrl.sv */
/*
  Serial controller, controller mode with clock phase one: drives select,
  serial clock and outgoing data, samples incoming data, one word per
  select frame.
  Assumes the configuration words stay put while a word is requested and
  the peripheral keeps its data stable around the sampling edge.
*/
// How it works
// - clock period is divider plus one cycles, two for divider 0
// - divider lives in format bits 15:8
// - polarity bit 17 sets idle clock level
// - control bit 0 drives pins; phase bit 16
// - clock active for half the period rounded down, idle for the rest
// - data out half period before capture edge
// - input sampled on capture edge per polarity
// - select to edge: half+delay+2, hold at polarity one +3
// - last edge to deselect: delay plus one
// - both delays come from delay word
// - period within 256 cycles, at least 25ns
`timescale 1ns/1ns
`default_nettype none
`include "scp_consts.svh"

module scp_ctrl #(
  parameter int DATA_W = 16,
  parameter int CLK_PERIOD_NS = 100
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  // configuration words
  input wire logic [31:0] global_control_register,
  input wire logic [31:0] format_config_register,
  input wire logic [31:0] delay_config_register,
  // transmit request
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [DATA_W-1:0] tx_data,
  // receive result
  output logic rx_valid,
  output logic [DATA_W-1:0] rx_data,
  output logic busy,
  // serial pins
  output logic select_n_out,
  output logic select_n_oe,
  output logic serial_clock_out,
  output logic serial_clock_oe,
  output logic controller_data_out,
  output logic controller_data_oe,
  input wire logic controller_data_in
);
  // ========================================================
  // elaboration checks
  // the shift path needs two bits at least; the length field stops at 16
  if (DATA_W < 2 || DATA_W > 16) begin : g_bad_width
    $error("DATA_W must lie in 2..16");
  end
  // shortest period is two bus cycles and must not undercut the floor
  if (2 * CLK_PERIOD_NS < `SCP_MIN_PERIOD_NS) begin : g_bad_clock
    $error("bus clock too fast for the shortest serial period");
  end

  // ========================================================
  // field decode
  wire logic ctrl_mode = global_control_register[`SCP_GCR_CTRL_BIT];
  wire logic phase_one = format_config_register[`SCP_FMT_PHASE_BIT];
  wire logic fmt_pol = format_config_register[`SCP_FMT_POL_BIT];
  wire logic fmt_hold = format_config_register[`SCP_FMT_HOLD_BIT];
  wire logic [7:0] fmt_div =
    format_config_register[`SCP_FMT_DIV_MSB:`SCP_FMT_DIV_LSB];
  wire logic [4:0] fmt_len =
    format_config_register[`SCP_FMT_LEN_MSB:`SCP_FMT_LEN_LSB];
  wire logic [7:0] dly_c2t =
    delay_config_register[`SCP_DLY_C2T_MSB:`SCP_DLY_C2T_LSB];
  wire logic [7:0] dly_t2c =
    delay_config_register[`SCP_DLY_T2C_MSB:`SCP_DLY_T2C_LSB];

  // ========================================================
  // state
  scp_pkg::scp_state_t state_q;
  scp_pkg::scp_state_t state_d;
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  logic [4:0] bits_q;
  logic [4:0] left_q;
  logic [4:0] left_d;
  logic [DATA_W-1:0] shift_q;
  logic [DATA_W-1:0] shift_d;
  logic [DATA_W-1:0] rx_data_q;
  logic rx_valid_q;
  logic pol_q;
  logic [7:0] div_q;
  logic [7:0] t2c_q;
  logic sel_n_q;
  logic sclk_q;
  logic sdo_q;

  // ========================================================
  // half-period timer
  logic half_tick;
  logic [8:0] period;
  logic [7:0] first_len;
  wire logic timer_run =
    (state_q == scp_pkg::ST_ACTIVE) || (state_q == scp_pkg::ST_INACTIVE);
  wire logic [7:0] timer_div = (state_q == scp_pkg::ST_IDLE) ? fmt_div : div_q;

  scp_half_timer u_timer (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .run(timer_run),
    .second_half(state_q == scp_pkg::ST_INACTIVE),
    .div(timer_div),
    .tick(half_tick),
    .period(period),
    .first_len(first_len)
  );

  // ========================================================
  // request decode
  // phase zero is not served: requests wait while it is selected
  assign tx_ready = (state_q == scp_pkg::ST_IDLE) && ctrl_mode && phase_one;
  wire logic start = tx_valid && tx_ready;
  wire logic [4:0] start_bits = (fmt_len == 5'h00 || 32'(fmt_len) > DATA_W) ?
    5'(DATA_W) : fmt_len;
  wire logic [DATA_W-1:0] start_shift =
    tx_data << (5'(DATA_W) - start_bits);
  // hold option with polarity one costs one more cycle
  wire logic [9:0] setup_extra = (fmt_hold && fmt_pol) ?
    `SCP_SETUP_EXTRA_HOLD : `SCP_SETUP_EXTRA;
  wire logic [9:0] setup_len =
    {2'b00, first_len} + {2'b00, dly_c2t} + setup_extra;
  wire logic cnt_done = (cnt_q == 10'h000);
  wire logic last_bit = (left_q == 5'h01);
  wire logic [DATA_W-1:0] rx_mask = ~({DATA_W{1'b1}} << bits_q);

  // ========================================================
  // sequencer next state
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    left_d = left_q;
    shift_d = shift_q;
    unique case (state_q)
      scp_pkg::ST_IDLE: begin
        if (start) begin
          state_d = scp_pkg::ST_SETUP;
          cnt_d = setup_len - 10'h001;
          left_d = start_bits;
          shift_d = start_shift;
        end
      end
      scp_pkg::ST_SETUP: begin
        cnt_d = cnt_q - 10'h001;
        if (cnt_done) begin
          state_d = scp_pkg::ST_ACTIVE;
        end
      end
      scp_pkg::ST_ACTIVE: begin
        if (half_tick) begin
          // capture edge: take one bit in, one bit consumed
          shift_d = {shift_q[DATA_W-2:0], controller_data_in};
          left_d = left_q - 5'h01;
          if (last_bit) begin
            state_d = scp_pkg::ST_HOLD;
            cnt_d = {2'b00, t2c_q};
          end else begin
            state_d = scp_pkg::ST_INACTIVE;
          end
        end
      end
      scp_pkg::ST_INACTIVE: begin
        if (half_tick) begin
          state_d = scp_pkg::ST_ACTIVE;
        end
      end
      scp_pkg::ST_HOLD: begin
        cnt_d = cnt_q - 10'h001;
        if (cnt_done) begin
          state_d = scp_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // edges as seen by the sequencer
  wire logic lead_edge = ((state_q == scp_pkg::ST_SETUP) && cnt_done) ||
    ((state_q == scp_pkg::ST_INACTIVE) && half_tick);
  wire logic trail_edge = (state_q == scp_pkg::ST_ACTIVE) && half_tick;
  wire logic frame_end = (state_q == scp_pkg::ST_HOLD) && cnt_done;

  // ========================================================
  // sequencer registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_q <= scp_pkg::ST_IDLE;
      cnt_q <= 10'h000;
      left_q <= 5'h00;
      shift_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      left_q <= left_d;
      shift_q <= shift_d;
    end
  end

  // configuration latched per word so a mid-word change cannot tear it
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pol_q <= 1'b0;
      div_q <= 8'h00;
      t2c_q <= 8'h00;
      bits_q <= 5'h00;
    end else if (ce && start) begin
      pol_q <= fmt_pol;
      div_q <= fmt_div;
      t2c_q <= dly_t2c;
      bits_q <= start_bits;
    end
  end

  // ========================================================
  // pin registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sel_n_q <= 1'b1;
      sclk_q <= 1'b0;
      sdo_q <= 1'b0;
    end else if (ce) begin
      if (start) begin
        sel_n_q <= 1'b0;
      end else if (frame_end) begin
        sel_n_q <= 1'b1;
      end
      if (state_q == scp_pkg::ST_IDLE) begin
        sclk_q <= fmt_pol;
      end else if (lead_edge) begin
        sclk_q <= ~pol_q;
        sdo_q <= shift_q[DATA_W-1];
      end else if (trail_edge) begin
        sclk_q <= pol_q;
      end
    end
  end

  // received word, one-cycle strobe at deselect
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_valid_q <= 1'b0;
      rx_data_q <= '0;
    end else if (ce) begin
      rx_valid_q <= frame_end;
      if (frame_end) begin
        rx_data_q <= shift_q & rx_mask;
      end
    end
  end

  // outputs; pins float when controller mode is off
  assign rx_valid = rx_valid_q;
  assign rx_data = rx_data_q;
  assign busy = (state_q != scp_pkg::ST_IDLE);
  assign select_n_out = sel_n_q;
  assign serial_clock_out = sclk_q;
  assign controller_data_out = sdo_q;
  assign select_n_oe = ctrl_mode;
  assign serial_clock_oe = ctrl_mode;
  assign controller_data_oe = ctrl_mode;

  // ========================================================
  // checks
  logic [9:0] since_q;
  logic [4:0] edges_q;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      since_q <= 10'h000;
      edges_q <= 5'h00;
    end else if (ce) begin
      if (start || lead_edge || trail_edge) begin
        since_q <= 10'h000;
      end else begin
        since_q <= since_q + 10'h001;
      end
      if (start) begin
        edges_q <= 5'h00;
      end else if (trail_edge) begin
        edges_q <= edges_q + 5'h01;
      end
    end
  end

  // idle period follows the live divider; only a running word uses the latch
  a_period_range: assert property (@(posedge mclk) disable iff (!rstn)
    period >= `SCP_DIV_ZERO_PERIOD && period <= `SCP_MAX_PERIOD_CYC &&
    (!busy || period == ((div_q == 8'h00) ? `SCP_DIV_ZERO_PERIOD :
    {1'b0, div_q} + 9'h001)))
    else $error("serial period out of range");
  a_idle_level: assert property (@(posedge mclk) disable iff (!rstn)
    ce && state_q == scp_pkg::ST_IDLE |=> serial_clock_out == $past(fmt_pol))
    else $error("idle clock level wrong");
  a_mode_gate: assert property (@(posedge mclk) disable iff (!rstn)
    !ctrl_mode |-> !serial_clock_oe && !controller_data_oe && !tx_ready)
    else $error("pins driven outside controller mode");
  a_half_length: assert property (@(posedge mclk) disable iff (!rstn)
    ce && trail_edge |-> since_q == {2'b00, first_len} - 10'h001)
    else $error("active half has wrong length");
  a_data_lead: assert property (@(posedge mclk) disable iff (!rstn)
    ce && $changed(controller_data_out) |-> serial_clock_out != pol_q)
    else $error("data changed away from leading edge");
  a_sample_edge: assert property (@(posedge mclk) disable iff (!rstn)
    ce && trail_edge |=> serial_clock_out == pol_q &&
    shift_q[0] == $past(controller_data_in))
    else $error("input not taken at capture edge");
  a_select_setup: assert property (@(posedge mclk) disable iff (!rstn)
    ce && (state_q == scp_pkg::ST_SETUP) && cnt_done |->
    since_q + 10'h001 == {2'b00, first_len} + {2'b00, dly_c2t} +
    ((fmt_hold && pol_q) ? `SCP_SETUP_EXTRA_HOLD : `SCP_SETUP_EXTRA))
    else $error("select to clock delay wrong");
  a_select_hold: assert property (@(posedge mclk) disable iff (!rstn)
    ce && frame_end |-> since_q == {2'b00, t2c_q} &&
    !select_n_out ##1 select_n_out)
    else $error("clock to select delay wrong");
  a_word_bits: assert property (@(posedge mclk) disable iff (!rstn)
    ce && frame_end |-> edges_q == bits_q ##1 rx_valid)
    else $error("word length mismatch");
endmodule // scp_ctrl
`default_nettype wire

/* File: bench/scp_periph_model.sv */
/*
  Behavioural peripheral on the far side of the phase-one serial
  controller: shifts a reply word out and captures the outgoing word.
  Assumes it shares mclk with the controller and sees registered pins.
*/
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// peripheral model
module scp_periph_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // settings from the bench
  input wire logic pol,
  input wire logic [4:0] nbits,
  input wire logic [15:0] reply,
  // serial pins
  input wire logic select_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  // captured word, low bits
  output logic [15:0] got_q
);
  logic sclk_q;
  logic last_q;
  logic [4:0] idx_q;
  logic trail;

  // trailing edge seen one mclk late, so our data stays put across it
  assign trail = (sclk_q != sclk) && (sclk == pol);
  // deselected line shows no stale bit: it flips every cycle
  assign miso = select_n ? ~last_q : reply[idx_q[3:0]];

  // bit pointer moves only after the controller has sampled
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sclk_q <= 1'b0;
      last_q <= 1'b0;
      idx_q <= 5'h00;
      got_q <= 16'h0000;
    end else begin
      sclk_q <= sclk;
      last_q <= miso;
      if (select_n) begin
        idx_q <= nbits - 5'h01;
      end else if (trail) begin
        idx_q <= idx_q - 5'h01;
        got_q <= {got_q[14:0], mosi};
      end
    end
  end
endmodule // scp_periph_model
`default_nettype wire

/* File: bench/spi_controller_phase_one_test.sv */
/*
  Self-checking bench of the phase-one serial controller: measures clock
  halves, select setup and hold, bit order and refusals at the pins.
  Assumes the design files and the peripheral model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module spi_controller_phase_one_test;
  logic mclk, rstn, ce, tx_valid, tx_ready, rx_valid, busy;
  logic [31:0] gcr, fmt, dly;
  logic [15:0] tx_data, rx_data, reply, got;
  logic sel_n, sel_oe, sclk, sclk_oe, dout, dout_oe, din, pol;
  logic [4:0] nbits;
  int err_total, n_checks;

  // ==========================================================
  // clock, design and far side
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  scp_ctrl #(.DATA_W(16), .CLK_PERIOD_NS(100)) dut (
    .mclk(mclk), .rstn(rstn), .ce(ce),
    .global_control_register(gcr), .format_config_register(fmt),
    .delay_config_register(dly),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_data(rx_data), .busy(busy),
    .select_n_out(sel_n), .select_n_oe(sel_oe),
    .serial_clock_out(sclk), .serial_clock_oe(sclk_oe),
    .controller_data_out(dout), .controller_data_oe(dout_oe),
    .controller_data_in(din)
  );

  scp_periph_model peer (
    .mclk(mclk), .rstn(rstn), .pol(pol), .nbits(nbits), .reply(reply),
    .select_n(sel_n), .sclk(sclk), .mosi(dout), .miso(din), .got_q(got)
  );

  // ==========================================================
  // shared helpers
  task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v);
    n_checks++;
    if (got_v !== exp_v) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one word with full pin timing measured against the walk
  task automatic run_word(input logic p, input logic hold,
      input logic [7:0] div, input logic [7:0] c2t, input logic [7:0] t2c,
      input logic [4:0] len, input logic [15:0] word,
      input logic [15:0] rep);
    int n, per, h1, h2, s, t, tf, tl, tr, nt, k;
    logic [15:0] mask;
    logic ps;
    n = (len == 5'h00 || len > 5'h10) ? 16 : len;
    per = (div == 8'h00) ? 2 : div + 1;
    h1 = per / 2;
    h2 = per - h1;
    s = h1 + c2t + 2 + (hold & p);
    mask = 16'hFFFF >> (16 - n);
    @(posedge mclk);
    fmt <= {3'h0, hold, 10'h000, p, 1'b1, div, 3'h0, len};
    dly <= {c2t, t2c, 16'h0000};
    gcr <= 32'h00000001;
    tx_data <= word;
    reply <= rep;
    pol <= p;
    nbits <= n[4:0];
    repeat (3) @(negedge mclk);
    check(sclk, p);
    check({sel_oe, sclk_oe, dout_oe}, 3'h7);
    @(posedge mclk);
    tx_valid <= 1'b1;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (tx_ready !== 1'b1 && k < 100);
    if (k >= 100) begin
      err_total++;
      print_verdict();
    end
    @(posedge mclk);
    tx_valid <= 1'b0;
    t = 0;
    nt = 0;
    tr = -1;
    tf = -1;
    tl = 0;
    ps = p;
    while (rx_valid !== 1'b1) begin
      @(negedge mclk);
      t++;
      // first cycle of the frame: busy, and no second request taken
      if (tf < 0 && sel_n === 1'b0) begin
        tf = t;
        check({busy, tx_ready}, 2'h2);
      end
      if (sclk !== ps) begin
        if (nt == 0) check(t - tf, s);
        else check(t - tl, (nt % 2) ? h1 : h2);
        if (sclk !== p) check(dout, word[n - 1 - nt / 2]);
        nt++;
        tl = t;
        ps = sclk;
      end
      if (tr < 0 && tf >= 0 && sel_n === 1'b1) tr = t;
      if (t > 3000) begin
        err_total++;
        print_verdict();
      end
    end
    // the result strobe rises at the same edge as deselect
    check(t - tr, 0);
    check(tr - tl, t2c + 1);
    check(nt, 2 * n);
    check(got & mask, word & mask);
    check(rx_data, rep & mask);
    check({busy, tx_ready}, 2'h1);
    // strobe stands for one cycle only
    @(negedge mclk);
    check(rx_valid, 1'b0);
  endtask

  // ==========================================================
  // scenarios
  task automatic sc_pol0_basic;
    run_word(1'b0, 1'b0, 8'h03, 8'h02, 8'h01, 5'h08, 16'h00A5,
      16'h003C);
  endtask

  // odd period: the extra cycle lands in the idle-level half
  task automatic sc_pol1_hold_odd;
    run_word(1'b1, 1'b1, 8'h04, 8'h00, 8'h00, 5'h00, 16'hC3A1,
      16'h5E96);
  endtask

  // hold option at polarity zero adds nothing; fastest divider
  task automatic sc_pol0_hold_fast;
    run_word(1'b0, 1'b1, 8'h00, 8'h01, 8'h03, 5'h05, 16'h0013,
      16'h000A);
  endtask

  // word length above the data width falls back to the full width
  task automatic sc_pol1_plain_wide;
    run_word(1'b1, 1'b0, 8'h01, 8'h03, 8'h02, 5'h11, 16'h8001,
      16'h7FFE);
  endtask

  task automatic sc_long_period;
    run_word(1'b1, 1'b0, 8'hFF, 8'hFF, 8'hFF, 5'h02, 16'h0002,
      16'h0001);
  endtask

  // no controller mode, then phase zero: requests must be held off
  task automatic sc_refused;
    @(posedge mclk);
    gcr <= 32'h00000000;
    fmt <= 32'h00010308;
    tx_valid <= 1'b1;
    repeat (8) begin
      @(negedge mclk);
      check({tx_ready, sel_n, sel_oe, sclk_oe, dout_oe}, 5'h08);
    end
    @(posedge mclk);
    gcr <= 32'h00000001;
    fmt <= 32'h00000308;
    repeat (8) begin
      @(negedge mclk);
      check({tx_ready, sel_n, sel_oe}, 3'h3);
    end
    @(posedge mclk);
    tx_valid <= 1'b0;
  endtask

  // clock enable low: the idle clock level must not follow polarity
  task automatic sc_freeze;
    @(posedge mclk);
    ce <= 1'b0;
    fmt <= 32'h00030308;
    repeat (3) @(negedge mclk);
    check(sclk, 1'b0);
    @(posedge mclk);
    ce <= 1'b1;
    repeat (2) @(negedge mclk);
    check(sclk, 1'b1);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    err_total = 0;
    n_checks = 0;
    rstn = 1'b0;
    ce = 1'b1;
    gcr = 32'h00000000;
    fmt = 32'h00000000;
    dly = 32'h00000000;
    tx_valid = 1'b0;
    tx_data = 16'h0000;
    reply = 16'h0000;
    pol = 1'b0;
    nbits = 5'h10;
    repeat (12) @(posedge mclk);
    check({sel_n, rx_valid}, 2'h2);
    rstn <= 1'b1;
    sc_pol0_basic();
    sc_pol1_hold_odd();
    sc_pol0_hold_fast();
    sc_pol1_plain_wide();
    sc_long_period();
    sc_refused();
    sc_freeze();
    print_verdict();
  end
endmodule // spi_controller_phase_one_test
`default_nettype wire
